//--- bwr_ctrl.sv
// Purpose: Burst latency, ready timing and bank busy tracking of a burst flash
// Assumes: Host drives start and word strobes synchronous to core_clk_in
// Notes: Array data arrives on a stream port and is buffered in a FIFO
`include "bwr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bwr_ctrl #(
    parameter int PROG_CYCLES = `BWR_PROG_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cfg_write_in,
    input wire logic [15:0] config_word_value_in,
    input wire logic fast_clock_in,
    input wire logic burst_start_in,
    input wire logic [3:0] burst_bank_in,
    input wire logic boundary_cross_in,
    input wire logic [3:0] cross_bank_in,
    input wire logic array_valid_in,
    output logic array_ready_out,
    input wire logic [15:0] array_data_in,
    input wire logic op_start_in,
    input wire logic op_erase_in,
    input wire logic [3:0] op_bank_in,
    output logic ready_out,
    output logic data_valid_out,
    output logic [15:0] data_out,
    output logic busy_out,
    output logic [3:0] busy_bank_out,
    output logic preprog_out,
    output logic [15:0] prog_word_out,
    output logic cfg_reserved_out
);
    import bwr_pkg::*;
    logic [15:0] cfg_q;
    bwr_burst_t bst_q;
    bwr_op_t op_q;
    logic [3:0] cnt_q;
    logic [3:0] busy_bank_q;
    logic [31:0] op_cnt_q;
    logic [15:0] data_q;
    logic dv_q;
    logic fifo_valid;
    logic [15:0] fifo_data;
    logic lead_sel;
    logic stall_need;
    logic word_now;
    logic ready_early;

    function automatic logic [3:0] total_latency(input logic [2:0] code);
        total_latency = `BWR_BASE_LATENCY + {1'b0, code};
    endfunction

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            cfg_q <= `BWR_CFG_RESET;
        end
        else if (cfg_write_in)
        begin
            cfg_q <= config_word_value_in;
        end
    end
    assign lead_sel = cfg_q[`BWR_CFG_READY_LEAD_BIT];
    assign cfg_reserved_out = cfg_q[`BWR_CFG_WAIT_MSB:`BWR_CFG_WAIT_LSB] > `BWR_WAIT_MAX_CODE;

    // Stall only on fast clock with crossing enabled, or crossing into the busy bank
    assign stall_need = boundary_cross_in && bst_q == BWR_STREAM &&
        ((fast_clock_in && cfg_q[`BWR_CFG_BOUNDARY_BIT]) ||
        (busy_out && cross_bank_in == busy_bank_q));

    // ------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            bst_q <= BWR_IDLE;
            cnt_q <= 4'h0;
        end
        else
        begin
            case (bst_q)
                BWR_IDLE:
                begin
                    if (burst_start_in)
                    begin
                        bst_q <= BWR_LAT;
                        cnt_q <= total_latency(cfg_q[`BWR_CFG_WAIT_MSB:`BWR_CFG_WAIT_LSB]) - 4'h1;
                    end
                end
                BWR_LAT:
                begin
                    if (cnt_q == 4'h1)
                    begin
                        bst_q <= BWR_STREAM;
                    end
                    cnt_q <= cnt_q - 4'h1;
                end
                BWR_STREAM:
                begin
                    if (burst_start_in)
                    begin
                        bst_q <= BWR_IDLE;
                    end
                    else if (stall_need)
                    begin
                        bst_q <= BWR_STALL;
                        cnt_q <= `BWR_EXTRA_WAIT;
                    end
                end
                default:
                begin
                    if (cnt_q == 4'h1)
                    begin
                        bst_q <= BWR_STREAM;
                    end
                    cnt_q <= cnt_q - 4'h1;
                end
            endcase
        end
    end

    // A word leaves every streaming clock when the buffer has one
    assign word_now = bst_q == BWR_STREAM && fifo_valid;
    // Early ready marks the clock that launches a word, one clock before it shows
    assign ready_early = bst_q == BWR_STREAM;

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            data_q <= 16'h0000;
            dv_q <= 1'b0;
        end
        else
        begin
            dv_q <= word_now;
            if (word_now)
            begin
                data_q <= fifo_data;
            end
        end
    end
    assign data_out = data_q;
    assign data_valid_out = dv_q;
    assign ready_out = lead_sel ? dv_q : (ready_early && fifo_valid);

    bwr_fifo #(.WIDTH(16), .DEPTH(8)) u_fifo (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .in_valid_in(array_valid_in),
        .in_ready_out(array_ready_out),
        .in_data_in(array_data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(word_now),
        .out_data_out(fifo_data)
    );

    // ------------------------------------------------------------
    // Embedded program and erase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            op_q <= BWR_BANK_IDLE;
            op_cnt_q <= 32'h0;
            busy_bank_q <= 4'h0;
        end
        else
        begin
            case (op_q)
                BWR_BANK_IDLE:
                begin
                    if (op_start_in)
                    begin
                        busy_bank_q <= op_bank_in;
                        op_q <= op_erase_in ? BWR_PREPROG : BWR_PROG;
                        op_cnt_q <= 32'(PROG_CYCLES) - 32'h1;
                    end
                end
                BWR_PREPROG:
                begin
                    if (op_cnt_q == 32'h0)
                    begin
                        op_q <= BWR_ERASE;
                        op_cnt_q <= 32'(`BWR_ERASE_CYCLES) - 32'h1;
                    end
                    else
                    begin
                        op_cnt_q <= op_cnt_q - 32'h1;
                    end
                end
                default:
                begin
                    if (op_cnt_q == 32'h0)
                    begin
                        op_q <= BWR_BANK_IDLE;
                    end
                    else
                    begin
                        op_cnt_q <= op_cnt_q - 32'h1;
                    end
                end
            endcase
        end
    end
    // Bursts keep running while a bank is busy; busy makes only a crossing into the busy bank stall
    assign busy_out = op_q != BWR_BANK_IDLE;
    assign busy_bank_out = busy_bank_q;
    assign preprog_out = op_q == BWR_PREPROG;
    assign prog_word_out = `BWR_ZERO_WORD;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ready_with_data: assert property (@(posedge core_clk_in) disable iff (rst_in)
        lead_sel |-> (ready_out == data_valid_out)) else $error("ready not with data");
    chk_ready_leads_data: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!lead_sel && ready_out && !cfg_write_in) |=> data_valid_out)
        else $error("ready did not lead data");
    chk_no_slow_stall: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!fast_clock_in && !cfg_q[`BWR_CFG_BOUNDARY_BIT] && !busy_out) |-> bst_q != BWR_STALL ##0 !stall_need)
        else $error("stall at slow clock");
    chk_latency_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (bst_q == BWR_IDLE && burst_start_in && cfg_q[13:11] == 3'h0) |-> ##1 bst_q == BWR_LAT ##1 bst_q == BWR_STREAM)
        else $error("latency wrong");
    chk_word_each_clk: assert property (@(posedge core_clk_in) disable iff (rst_in)
        word_now |=> data_valid_out && data_out == $past(fifo_data)) else $error("word missed");
    chk_preprog_first: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (op_q == BWR_BANK_IDLE && op_start_in && op_erase_in) |=> preprog_out) else $error("no preprogram");
    chk_stall_len: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (bst_q == BWR_STREAM && stall_need && !burst_start_in) |=> (bst_q == BWR_STALL)[*2] ##1 bst_q == BWR_STREAM)
        else $error("stall length wrong");
    chk_busy_reads: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (busy_out && bst_q == BWR_STREAM && fifo_valid) |=> data_valid_out) else $error("read blocked");
    cov_burst: cover property (@(posedge core_clk_in) word_now ##1 word_now);
    cov_stall: cover property (@(posedge core_clk_in) bst_q == BWR_STALL);
    cov_erase: cover property (@(posedge core_clk_in) op_q == BWR_ERASE);
endmodule
`default_nettype wire

//--- bwr_defs.svh
// Purpose: Constants for the burst wait-state and ready controller
// Assumes: Configuration word is sixteen bits wide
// Notes: Program cycle count derives from the 40 MHz core clock; erase count is a fixed 16
`ifndef BWR_DEFS_SVH
`define BWR_DEFS_SVH
`define BWR_CFG_READY_LEAD_BIT 8
`define BWR_CFG_BOUNDARY_BIT 14
`define BWR_CFG_WAIT_MSB 13
`define BWR_CFG_WAIT_LSB 11
`define BWR_CFG_RESET 16'hFFFF
`define BWR_WAIT_MAX_CODE 3'h5
`define BWR_BASE_LATENCY 4'h2
`define BWR_EXTRA_WAIT 4'h2
`define BWR_CLK_MHZ 40
`define BWR_PROG_TYP_US 40
`define BWR_PROG_MAX_US 400
`define BWR_PROG_CYCLES (`BWR_PROG_TYP_US * `BWR_CLK_MHZ)
`define BWR_ERASE_CYCLES 16
`define BWR_ZERO_WORD 16'h0000
`endif

//--- bwr_pkg.sv
// Purpose: Types for the burst wait-state and ready controller
// Assumes: Nothing beyond the defs header
// Notes: Types only
package bwr_pkg;
    typedef enum logic [1:0] {BWR_IDLE, BWR_LAT, BWR_STREAM, BWR_STALL} bwr_burst_t;
    typedef enum logic [1:0] {BWR_BANK_IDLE, BWR_PREPROG, BWR_ERASE, BWR_PROG} bwr_op_t;
endpackage

//--- bwr_fifo.sv
// Purpose: Small FIFO holding burst words before the output pins
// Assumes: Synchronous reset, one clock
// Notes: Full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module bwr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- bwr_host.sv
// Purpose: Host controller model issuing configuration, bursts and operations
// Assumes: Outputs change just after rising edges of clk_in
// Notes: A released configuration word shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module bwr_host (
    input wire logic clk_in,
    input wire logic busy_in,
    output logic cfg_write_out,
    output logic [15:0] cfg_word_out,
    output logic start_out,
    output logic op_start_out,
    output logic op_erase_out,
    output logic [3:0] op_bank_out
);
    initial
    begin
        cfg_write_out = 1'b0;
        cfg_word_out = 16'h0000;
        start_out = 1'b0;
        op_start_out = 1'b0;
        op_erase_out = 1'b0;
        op_bank_out = 4'h0;
    end
    task automatic load_cfg(input logic [15:0] w);
        @(posedge clk_in);
        cfg_word_out <= w;
        cfg_write_out <= 1'b1;
        @(posedge clk_in);
        cfg_write_out <= 1'b0;
        cfg_word_out <= ~w;
    endtask
    task automatic burst_pulse();
        @(posedge clk_in);
        start_out <= 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
    endtask
    task automatic op(input logic erase, input logic [3:0] bank);
        @(posedge clk_in);
        op_start_out <= 1'b1;
        op_erase_out <= erase;
        op_bank_out <= bank;
        @(posedge clk_in);
        op_start_out <= 1'b0;
        op_bank_out <= ~bank;
    endtask
    // Busy is reported only when two successive reads both show it
    task automatic poll(output logic b);
        logic first;
        @(posedge clk_in);
        first = busy_in;
        @(posedge clk_in);
        b = first & busy_in;
    endtask
endmodule
`default_nettype wire

//--- bwr_ctrl_test.sv
// Purpose: Self-checking bench for the burst wait-state and ready controller
// Assumes: PROG_CYCLES shortened to 8
// Notes: Array words are preloaded into the FIFO before each burst
`timescale 1ns/1ps
`default_nettype none
module bwr_ctrl_test;
    localparam int PROG = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic av = 1'b0;
    logic [15:0] ad = 16'h0000;
    logic fc = 1'b0;
    logic cb = 1'b0;
    logic [3:0] bc = 4'h0;
    logic cw, bs, os, oe, arr_rdy, rdy, dv, busy, pp, resv;
    logic [15:0] cv, dq, pw;
    logic [3:0] ob, bbank;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    bwr_host host (.clk_in(clk), .busy_in(busy), .cfg_write_out(cw), .cfg_word_out(cv),
        .start_out(bs), .op_start_out(os), .op_erase_out(oe), .op_bank_out(ob));
    bwr_ctrl #(.PROG_CYCLES(PROG)) dut_u (.core_clk_in(clk), .rst_in(rst), .cfg_write_in(cw),
        .config_word_value_in(cv), .fast_clock_in(fc), .burst_start_in(bs),
        .burst_bank_in(4'h1), .boundary_cross_in(cb), .cross_bank_in(bc),
        .array_valid_in(av), .array_ready_out(arr_rdy), .array_data_in(ad),
        .op_start_in(os), .op_erase_in(oe), .op_bank_in(ob), .ready_out(rdy),
        .data_valid_out(dv), .data_out(dq), .busy_out(busy), .busy_bank_out(bbank),
        .preprog_out(pp), .prog_word_out(pw), .cfg_reserved_out(resv));
    task automatic close_out();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_on(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 14)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // Fill until the FIFO refuses
    task automatic fill(input logic [15:0] base);
        int n;
        n = 0;
        @(posedge clk);
        av <= 1'b1;
        ad <= base;
        repeat (11)
        begin
            @(posedge clk);
            if (arr_rdy === 1'b1)
            begin
                n++;
                ad <= base + 16'(n);
            end
        end
        av <= 1'b0;
        ad <= ~ad;
        chk("fifo_count", 16'h0008, 16'(n));
    endtask
    task automatic lat(input logic [2:0] code, input logic lead);
        int n;
        logic [15:0] base;
        base = {5'h00, code, 7'h00, lead};
        host.load_cfg({2'b00, code, 2'b00, lead, 8'h00});
        fill(base);
        host.burst_pulse();
        #1;
        n = 0;
        while (rdy !== 1'b1 && n < 12)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("ready_delay", 16'(code) + 16'h0001 + 16'(lead), 16'(n));
        wait_on(dv);
        for (int k = 0; k < 8; k++)
        begin
            chk("burst_word", base + 16'(k), dq);
            if (k < 7)
                chk("ready_hold", 16'h0001, 16'(rdy));
            @(posedge clk);
            #1;
        end
        host.burst_pulse();
    endtask
    task automatic stall(input logic fast, input logic bnd, input logic bsy, input int exp);
        int low;
        logic b;
        host.load_cfg({1'b0, bnd, 14'h0100});
        fill(16'h0A00);
        fc <= fast;
        if (bsy)
            host.op(1'b1, 4'h3);
        host.burst_pulse();
        wait_on(dv);
        @(posedge clk);
        cb <= 1'b1;
        bc <= 4'h3;
        @(posedge clk);
        cb <= 1'b0;
        bc <= 4'hC;
        low = 0;
        repeat (6)
        begin
            #1;
            if (rdy !== 1'b1)
                low++;
            @(posedge clk);
        end
        chk("stall_cycles", 16'(exp), 16'(low));
        if (bsy)
        begin
            host.poll(b);
            chk("busy_poll", 16'h0001, 16'(b));
        end
        repeat (8) @(posedge clk);
        host.burst_pulse();
        fc <= 1'b0;
    endtask
    task automatic ops(input logic erase);
        int nb;
        int np;
        wait_on(resv);
        repeat (30) @(posedge clk);
        host.op(erase, 4'h5);
        #1;
        chk("busy_bank", 16'h0005, 16'(bbank));
        chk("zero_word", 16'h0000, pw);
        nb = 0;
        np = 0;
        repeat (40)
        begin
            if (busy === 1'b1)
                nb++;
            if (pp === 1'b1)
                np++;
            @(posedge clk);
            #1;
        end
        chk("busy_cycles", 16'(PROG + (erase ? 16 : 0)), 16'(nb));
        chk("preprog_cycles", erase ? 16'(PROG) : 16'h0000, 16'(np));
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset_reserved", 16'h0001, 16'(resv));
        chk("reset_ready", 16'h0000, 16'(rdy));
        host.load_cfg(16'h3000);
        #1;
        chk("code6_reserved", 16'h0001, 16'(resv));
        for (int c = 0; c < 6; c++)
            lat(3'(c), 1'b0);
        lat(3'h0, 1'b1);
        lat(3'h5, 1'b1);
        chk("code5_reserved", 16'h0000, 16'(resv));
        stall(1'b1, 1'b1, 1'b0, 2);
        stall(1'b0, 1'b0, 1'b0, 0);
        stall(1'b0, 1'b0, 1'b1, 2);
        ops(1'b0);
        ops(1'b1);
        close_out();
    end
endmodule
`default_nettype wire
